// ---- design/trace_sram_defs.svh ----
`ifndef TRACE_SRAM_DEFS_SVH
`define TRACE_SRAM_DEFS_SVH

// ----------------------------------------------------------------
// Build options
// ----------------------------------------------------------------
`define TS_TRACE_OPTION   1
`define TS_RAM_AW         6
`define TS_GRP_W          128
`define TS_HDR_W          8
`define TS_WORDS          (`TS_GRP_W / 32)
`define TS_POS_W          4

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define TS_PADDR_W        12
`define TS_OFF_RD_ADDR    12'h040
`define TS_OFF_RD_DATA    12'h044
`define TS_OFF_WR_ADDR    12'h048
`define TS_OFF_WR_DATA    12'h04c
`define TS_WRAP_BIT       31

// ----------------------------------------------------------------
// Reset values and positions
// ----------------------------------------------------------------
`define TS_POS_HDR        4'h0
`define TS_POS_LAST       4'(`TS_WORDS)
`define TS_ADDR_RST       6'h00
`define TS_ADDR_MAX       6'h3f
`define TS_WORD_RST       32'h0000_0000

`endif

// ---- design/trace_sram_pkg.sv ----
`include "trace_sram_defs.svh"

package trace_sram_pkg;

  // One trace SRAM entry: header byte above the capture payload
  typedef struct packed {
    logic [`TS_HDR_W-1:0] hdr;
    logic [`TS_GRP_W-1:0] payload;
  } sram_entry_t;

endpackage

// ---- design/trace_sram_store.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "trace_sram_defs.svh"

module trace_sram_store (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        wr_en,
  input  wire logic [`TS_RAM_AW-1:0]       wr_addr,
  input  wire trace_sram_pkg::sram_entry_t wr_entry,
  input  wire logic                        rd_en,
  input  wire logic [`TS_RAM_AW-1:0]       rd_addr,
  output var  trace_sram_pkg::sram_entry_t rd_entry
);

  trace_sram_pkg::sram_entry_t mem_q [2**`TS_RAM_AW];

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_entry;
    end
  end

  // One cycle read latency
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_entry <= '0;
    end else if (rd_en) begin
      rd_entry <= mem_q[rd_addr];
    end
  end

endmodule

`default_nettype wire

// ---- design/trace_sram_access_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "trace_sram_defs.svh"

// Notes on behaviour
// - The four registers exist only when the trace option parameter is one.
// - Writing the read pointer fetches that SRAM entry into the read holding register.
// - After the fetched entry lands, the read pointer steps by one.
// - First data read after a pointer write returns the header byte, zero-extended.
// - Later data reads return payload words, least significant word first.
// - After the last payload word is read, the next entry is fetched and pointer steps.
// - The read pointer wraps to zero past the last SRAM location.
// - Writing the write pointer sets where host-written entries will be stored.
// - Reading the write pointer returns the next location to be written by anyone.
// - After trace stops, the write pointer is last written location plus one.
// - Bit 31 sets when capture, with capture_active high, advances the write pointer past the top.
// - Rollover from host data writes leaves the wrap flag unchanged.
// - A host write that commits an entry advances the write pointer.
// - First data write sets header byte, then payload words, last one commits to SRAM.
module trace_sram_access_port #(
  parameter int capture_group_width_param = `TS_GRP_W,
  parameter int trace_option_param        = `TS_TRACE_OPTION
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [`TS_PADDR_W-1:0]      paddr,
  input  wire logic [31:0]                 pwdata,
  output var  logic [31:0]                 prdata,
  output var  logic                        pready,
  input  wire logic                        run,
  input  wire logic                        capture_active,
  input  wire logic                        capture_wr,
  input  wire trace_sram_pkg::sram_entry_t capture_entry,
  output var  logic [`TS_RAM_AW-1:0]       write_pointer,
  output var  logic                        wrap_flag
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] word_of(input logic [`TS_GRP_W-1:0] p,
                                          input logic [`TS_POS_W-1:0] pos);
    int idx;
    idx = int'(pos) - 1;
    word_of = p[idx*32 +: 32];
  endfunction

  function automatic logic [`TS_GRP_W-1:0] put_word(input logic [`TS_GRP_W-1:0] p,
                                                    input logic [`TS_POS_W-1:0] pos,
                                                    input logic [31:0]          w);
    logic [`TS_GRP_W-1:0] r;
    int                   idx;
    r = p;
    idx = int'(pos) - 1;
    r[idx*32 +: 32] = w;
    put_word = r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [`TS_RAM_AW-1:0]       ra_q;
  logic [`TS_RAM_AW-1:0]       wa_q;
  logic                        wrap_q;
  logic [`TS_POS_W-1:0]        rpos_q;
  logic [`TS_POS_W-1:0]        wpos_q;
  logic                        fetch_pend_q;
  trace_sram_pkg::sram_entry_t rhold_q;
  trace_sram_pkg::sram_entry_t whold_q;
  trace_sram_pkg::sram_entry_t sram_rd;
  logic                        pready_q;
  logic [31:0]                 prdata_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Option gate
  wire reg_en   = (trace_option_param == 1);
  wire acc      = psel & penable & ~pready_q;
  wire wr_acc   = acc & pwrite;
  wire rd_acc   = acc & ~pwrite;
  wire hit_ra   = reg_en & (paddr == `TS_OFF_RD_ADDR);
  wire hit_rd   = reg_en & (paddr == `TS_OFF_RD_DATA);
  wire hit_wa   = reg_en & (paddr == `TS_OFF_WR_ADDR);
  wire hit_wd   = reg_en & (paddr == `TS_OFF_WR_DATA);
  wire ra_wr    = wr_acc & hit_ra;
  wire wa_wr    = wr_acc & hit_wa;
  wire rd_data  = rd_acc & hit_rd;
  wire wd_wr    = wr_acc & hit_wd;
  wire rd_last  = rd_data & (rpos_q == `TS_POS_LAST);
  wire wd_last  = wd_wr & (wpos_q == `TS_POS_LAST);
  wire [`TS_RAM_AW-1:0] pw_addr = pwdata[`TS_RAM_AW-1:0];

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Fetch on pointer write or on the last payload word read
  wire                  fetch_go   = ra_wr | rd_last;
  wire [`TS_RAM_AW-1:0] fetch_addr = ra_wr ? pw_addr : ra_q;

  wire [31:0] hdr_word = {{(32-`TS_HDR_W){1'b0}}, rhold_q.hdr};
  wire [31:0] pay_word = word_of(rhold_q.payload, rpos_q);
  wire [31:0] rd_word  = (rpos_q == `TS_POS_HDR) ? hdr_word : pay_word;

  wire [31:0] rd_val = hit_ra ? {{(32-`TS_RAM_AW){1'b0}}, ra_q} :
                       hit_rd ? rd_word :
                       hit_wa ? {wrap_q, {(31-`TS_RAM_AW){1'b0}}, wa_q} :
                       `TS_WORD_RST;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ra_q         <= `TS_ADDR_RST;
      rpos_q       <= `TS_POS_HDR;
      fetch_pend_q <= 1'b0;
      rhold_q      <= '0;
    end else begin
      fetch_pend_q <= fetch_go;
      if (ra_wr) begin
        ra_q <= pw_addr;
      // Step after landing; wraps by width
      end else if (fetch_pend_q) begin
        ra_q <= ra_q + 1'b1;
      end
      if (fetch_pend_q) begin
        rhold_q <= sram_rd;
      end
      if (ra_wr || rd_last) begin
        rpos_q <= `TS_POS_HDR;
      end else if (rd_data) begin
        rpos_q <= rpos_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // Capture wins; host is idle while running
  wire                         cap_go   = capture_wr;
  wire                         host_cmt = wd_last & ~cap_go;
  trace_sram_pkg::sram_entry_t host_entry;
  trace_sram_pkg::sram_entry_t wr_entry;

  assign host_entry = {whold_q.hdr, put_word(whold_q.payload, wpos_q, pwdata)};
  assign wr_entry           = cap_go ? capture_entry : host_entry;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wa_q    <= `TS_ADDR_RST;
      wrap_q  <= 1'b0;
      wpos_q  <= `TS_POS_HDR;
      whold_q <= '0;
    end else begin
      // Capture leaves pointer one past last entry
      if (cap_go) begin
        wa_q <= wa_q + 1'b1;
      end else if (wa_wr) begin
        wa_q <= pw_addr;
      end else if (host_cmt) begin
        wa_q <= wa_q + 1'b1;
      end
      // Capture rollover sets wrap; set beats the clear
      if (cap_go && capture_active && (wa_q == `TS_ADDR_MAX)) begin
        wrap_q <= 1'b1;
      // Host write loads the flag, expected zero
      end else if (wa_wr) begin
        wrap_q <= pwdata[`TS_WRAP_BIT];
      end
      if (wd_wr && (wpos_q == `TS_POS_HDR)) begin
        whold_q.hdr <= pwdata[`TS_HDR_W-1:0];
      end else if (wd_wr) begin
        whold_q.payload <= host_entry.payload;
      end
      if (wa_wr || wd_last) begin
        wpos_q <= `TS_POS_HDR;
      end else if (wd_wr) begin
        wpos_q <= wpos_q + 1'b1;
      end
    end
  end

  trace_sram_store u_store (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .wr_en    (cap_go | host_cmt),
    .wr_addr  (wa_q),
    .wr_entry (wr_entry),
    .rd_en    (fetch_go),
    .rd_addr  (fetch_addr),
    .rd_entry (sram_rd)
  );

  // ----------------------------------------------------------------
  // Bus answer, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      prdata_q <= `TS_WORD_RST;
    end else begin
      pready_q <= acc;
      prdata_q <= rd_acc ? rd_val : `TS_WORD_RST;
    end
  end

  assign pready        = pready_q;
  assign prdata        = prdata_q;
  assign write_pointer = wa_q;
  assign wrap_flag     = wrap_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_fetch_step;
    @(posedge mclk) disable iff (!rst_n)
      ra_wr |=> ##1 (ra_q == `TS_RAM_AW'($past(pw_addr, 2) + 1'b1));
  endproperty
  a_fetch_step: assert property (p_fetch_step) else $error("read pointer not stepped");

  property p_fetch_data;
    @(posedge mclk) disable iff (!rst_n)
      ra_wr |=> ##1 (rhold_q == $past(u_store.mem_q[pw_addr], 2));
  endproperty
  a_fetch_data: assert property (p_fetch_data) else $error("holding register not loaded");

  property p_hdr_first;
    @(posedge mclk) disable iff (!rst_n)
      ra_wr ##1 (!acc)[*3] ##1 (rd_data && !ra_wr) |=> (prdata_q == $past(hdr_word));
  endproperty
  a_hdr_first: assert property (p_hdr_first) else $error("header not returned first");

  property p_payload;
    @(posedge mclk) disable iff (!rst_n)
      (rd_data && rpos_q != `TS_POS_HDR) |=> (prdata_q == $past(pay_word)) && pready;
  endproperty
  a_payload: assert property (p_payload) else $error("payload word wrong");

  property p_refill;
    @(posedge mclk) disable iff (!rst_n)
      rd_last |=> fetch_pend_q ##1 (ra_q == `TS_RAM_AW'($past(ra_q, 2) + 1'b1));
  endproperty
  a_refill: assert property (p_refill) else $error("no refill after last word");

  property p_ra_wrap;
    @(posedge mclk) disable iff (!rst_n)
      (fetch_pend_q && !ra_wr && ra_q == `TS_ADDR_MAX) |=> (ra_q == `TS_ADDR_RST);
  endproperty
  a_ra_wrap: assert property (p_ra_wrap) else $error("read pointer did not wrap");

  property p_wa_load;
    @(posedge mclk) disable iff (!rst_n)
      (wa_wr && !cap_go) |=> (write_pointer == $past(pw_addr));
  endproperty
  a_wa_load: assert property (p_wa_load) else $error("write pointer not loaded");

  property p_wa_read;
    @(posedge mclk) disable iff (!rst_n)
      (rd_acc && hit_wa) |=> (prdata_q[`TS_RAM_AW-1:0] == $past(wa_q));
  endproperty
  a_wa_read: assert property (p_wa_read) else $error("write pointer readback wrong");

  property p_cap_wrap;
    @(posedge mclk) disable iff (!rst_n)
      (cap_go && capture_active && wa_q == `TS_ADDR_MAX) |=> wrap_flag && (write_pointer == 0);
  endproperty
  a_cap_wrap: assert property (p_cap_wrap) else $error("capture wrap not flagged");

  property p_host_nowrap;
    @(posedge mclk) disable iff (!rst_n)
      (host_cmt && !wa_wr) |=> (wrap_flag == $past(wrap_q));
  endproperty
  a_host_nowrap: assert property (p_host_nowrap) else $error("host rollover changed wrap");

  property p_commit;
    @(posedge mclk) disable iff (!rst_n)
      host_cmt |=> (wa_q == `TS_RAM_AW'($past(wa_q) + 1'b1)) && (wpos_q == `TS_POS_HDR);
  endproperty
  a_commit: assert property (p_commit) else $error("host commit did not advance");

  property p_pos_reset;
    @(posedge mclk) disable iff (!rst_n)
      ra_wr |=> (rpos_q == `TS_POS_HDR);
  endproperty
  a_pos_reset: assert property (p_pos_reset) else $error("read position not reset");

  property p_ready_pulse;
    @(posedge mclk) disable iff (!rst_n)
      acc |=> pready ##1 !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready not a single pulse");

  c_refill:    cover property (@(posedge mclk) disable iff (!rst_n) rd_last);
  c_host_cmt:  cover property (@(posedge mclk) disable iff (!rst_n) host_cmt);
  c_cap_wrap:  cover property (@(posedge mclk) disable iff (!rst_n)
                               cap_go && capture_active && wa_q == `TS_ADDR_MAX);
  c_run_cap:   cover property (@(posedge mclk) disable iff (!rst_n)
                               run && cap_go);

endmodule

`default_nettype wire

// ---- bench/apb_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module apb_host_model (
  input  wire logic        mclk,
  input  wire logic        run,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // One APB transfer, held until pready is seen on a rising edge or eight edges pass
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    while (run !== 1'b0) @(posedge mclk);
    @(posedge mclk);
    #1;
    psel   = 1'b1;
    pwrite = wr;
    paddr  = a;
    pwdata = d;
    @(posedge mclk);
    #1;
    penable = 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    q = (pready === 1'b1) ? prdata : 32'hxxxx_xxxx;
    #1;
    psel    = 1'b0;
    penable = 1'b0;
    // Stale data must not look valid
    pwdata  = ~pwdata;
  endtask
endmodule

`default_nettype wire

// ---- bench/tb_trace_sram_access_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "trace_sram_defs.svh"

module tb_trace_sram_access_port;
  logic                        mclk, rst_n, psel, penable, pwrite, pready;
  logic                        run, capture_active, capture_wr, wrap_flag;
  logic [11:0]                 paddr;
  logic [31:0]                 pwdata, prdata;
  logic [5:0]                  write_pointer;
  logic [5:0]                  off_wp;
  logic [31:0]                 off_prdata;
  logic                        off_pready;
  trace_sram_pkg::sram_entry_t capture_entry;
  int                          num_errors, total_checks, cycles;
  localparam logic [11:0]      a_ra = `TS_OFF_RD_ADDR;
  localparam logic [11:0]      a_rd = `TS_OFF_RD_DATA;
  localparam logic [11:0]      a_wa = `TS_OFF_WR_ADDR;
  localparam logic [11:0]      a_wd = `TS_OFF_WR_DATA;

  trace_sram_access_port u_dut (
    .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .run, .capture_active, .capture_wr, .capture_entry, .write_pointer, .wrap_flag
  );

  // Same bus, option off: registers must be absent
  trace_sram_access_port #(.trace_option_param(0)) u_dut_off (
    .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .run, .capture_entry,
    .prdata         (off_prdata),
    .pready         (off_pready),
    .capture_active (1'b0),
    .capture_wr     (1'b0),
    .write_pointer  (off_wp),
    .wrap_flag      ()
  );

  apb_host_model u_host (
    .mclk, .run, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Option off: every answer reads zero
  always @(posedge mclk) begin
    if (off_pready === 1'b1) begin
      check(off_prdata, 32'h0);
    end
  end

  function automatic logic [31:0] pw(input logic [7:0] t, input int i);
    return {16'hc0de, t, 8'(i)};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
    // Writes answer zero; a lost ready shows as unknown
    check(q, 32'h0);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_host.xfer(1'b0, a, 32'h0, q);
    check(q, e);
  endtask

  // Upper bytes of the header write are junk on purpose
  task automatic hw_entry(input logic [7:0] t);
    wr(a_wd, {24'h5a5a5a, t});
    for (int i = 0; i < 4; i++) wr(a_wd, pw(t, i));
  endtask

  task automatic chk_entry(input logic [7:0] t);
    rd_chk(a_rd, {24'h0, t});
    for (int i = 0; i < 4; i++) rd_chk(a_rd, pw(t, i));
  endtask

  task automatic port_chk(input logic [5:0] wp, input logic wf);
    repeat (2) @(posedge mclk);
    #1;
    check({26'h0, write_pointer}, {26'h0, wp});
    check({31'h0, wrap_flag}, {31'h0, wf});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    #1;
    check({30'h0, pready, wrap_flag}, 32'h0);
    check(prdata, 32'h0);
    check({26'h0, write_pointer}, 32'h0);
    rst_n = 1'b1;
    rd_chk(a_wa, 32'h0);
    rd_chk(a_ra, 32'h0);
    $display("test reset finished");
  endtask

  task automatic t_host_write();
    wr(a_wa, 32'h0000_0005);
    wr(a_wd, 32'h1111_1111);
    wr(a_wd, 32'h2222_2222);
    wr(a_wa, 32'h0000_0005);
    hw_entry({2'b10, 6'd5});
    port_chk(6'd6, 1'b0);
    hw_entry({2'b10, 6'd6});
    rd_chk(a_wa, 32'h0000_0007);
    $display("test host write finished");
  endtask

  task automatic t_stream_read();
    wr(a_ra, 32'h0000_0005);
    rd_chk(a_ra, 32'h0000_0006);
    rd_chk(a_rd, {24'h0, 2'b10, 6'd5});
    rd_chk(a_rd, pw({2'b10, 6'd5}, 0));
    wr(a_ra, 32'h0000_0005);
    chk_entry({2'b10, 6'd5});
    rd_chk(a_ra, 32'h0000_0007);
    chk_entry({2'b10, 6'd6});
    $display("test stream read finished");
  endtask

  task automatic t_rollover();
    wr(a_wa, 32'h0000_003f);
    hw_entry({2'b10, 6'd63});
    hw_entry({2'b10, 6'd0});
    port_chk(6'd1, 1'b0);
    wr(a_ra, 32'h0000_003f);
    chk_entry({2'b10, 6'd63});
    chk_entry({2'b10, 6'd0});
    rd_chk(a_ra, 32'h0000_0002);
    $display("test rollover finished");
  endtask

  task automatic t_capture();
    logic [7:0] t;
    wr(a_wa, 32'h0000_003e);
    run = 1'b1;
    capture_active = 1'b1;
    for (int k = 0; k < 3; k++) begin
      t = {2'b01, 6'(62 + k)};
      capture_wr = 1'b1;
      capture_entry = {t, pw(t, 3), pw(t, 2), pw(t, 1), pw(t, 0)};
      @(posedge mclk);
      #1;
    end
    capture_wr = 1'b0;
    capture_active = 1'b0;
    run = 1'b0;
    port_chk(6'd1, 1'b1);
    rd_chk(a_wa, 32'h8000_0001);
    wr(a_ra, 32'h0000_003e);
    for (int k = 0; k < 3; k++) chk_entry({2'b01, 6'(62 + k)});
    wr(a_wa, 32'h0000_0003);
    port_chk(6'd3, 1'b0);
    $display("test capture finished");
  endtask

  task automatic t_unmapped();
    wr(12'h050, 32'hffff_ffff);
    rd_chk(12'h050, 32'h0);
    rd_chk(a_wd, 32'h0);
    wr(a_rd, 32'hffff_ffff);
    rd_chk(a_wa, 32'h0000_0003);
    check({26'h0, off_wp}, 32'h0);
    $display("test unmapped finished");
  endtask

  initial begin
    rst_n          = 1'b0;
    run            = 1'b0;
    capture_active = 1'b0;
    capture_wr     = 1'b0;
    capture_entry  = '0;
    num_errors     = 0;
    total_checks   = 0;
    cycles         = 0;
    repeat (2) @(posedge mclk);
    t_reset();
    t_host_write();
    t_stream_read();
    t_rollover();
    t_capture();
    t_unmapped();
    print_verdict();
  end
endmodule

`default_nettype wire
